// *** design/tape_status_report_port.sv ***
// Status reporting side of the tape drive host port
`default_nettype none

module tape_status_report_port #(
  parameter int SELF_TEST_CYC = status_port_pkg::SELF_TEST_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Host port pins (active high logic levels)
  input wire logic host_reset_i,
  input wire logic request_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o,
  output logic bus_oe_n_o,
  output logic ready_o,
  output logic ack_o,
  output logic exception_o,
  output logic bus_direction_o,
  // Drive internals
  input wire status_port_pkg::event_type events_i,
  input wire status_port_pkg::cond_type cond_i,
  input wire logic self_test_en_i,
  input wire logic self_test_pass_i,
  // Command pass-through to the rest of the controller
  output logic [7:0] cmd_o,
  output logic cmd_valid_o
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD_WAIT = 7'b0000010,
    ST_CMD_DROP = 7'b0000100,
    ST_BYTE_GAP = 7'b0001000,
    ST_BYTE_RDY = 7'b0010000,
    ST_BYTE_REL = 7'b0100000,
    ST_SELFTEST = 7'b1000000
  } state_type;

  state_type state_r;
  logic [status_port_pkg::CNT_W-1:0] tmr_r;
  logic [31:0] test_tmr_r;
  logic [2:0] idx_r;
  logic req_s;
  logic hrst_s;
  logic hrst_d_r;
  logic req_d_r;
  logic req_rise;
  logic req_fall;
  logic read_done;
  logic [7:0] byte0_r;
  logic [7:0] byte1_r;
  logic [15:0] soft_cnt_r;
  logic [15:0] stall_cnt_r;
  logic [7:0] byte0_view;
  logic [7:0] byte1_view;
  logic [7:0] sel_byte;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync u_req_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .init_i(1'b0),
    .pin_i(request_i),
    .level_o(req_s)
  );

  pin_sync u_rst_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .init_i(1'b0),
    .pin_i(host_reset_i),
    .level_o(hrst_s)
  );

  // Edge detection on the filtered levels
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_d_r <= 1'b0;
      hrst_d_r <= 1'b0;
    end else begin
      req_d_r <= req_s;
      hrst_d_r <= hrst_s;
    end
  end

  assign req_rise = req_s & ~req_d_r;
  assign req_fall = ~req_s & req_d_r;

  // Clear-on-read happens once the last byte's request drops
  assign read_done = (state_r == ST_BYTE_REL) && req_fall &&
    (idx_r == status_port_pkg::LAST_BYTE_IDX);

  // ----------------------------------------
  // Saturating increment shared by both counters
  // ----------------------------------------
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ----------------------------------------
  // Status byte 0 sticky event bits
  // ----------------------------------------
  // Set wins over the read clear, so no event is lost in the clear cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte0_r <= status_port_pkg::BYTE0_RESET;
    end else begin
      if (read_done) begin
        byte0_r[status_port_pkg::B0_FILE_MARK] <= 1'b0;
        byte0_r[status_port_pkg::B0_BAD_BLOCK] <= 1'b0;
        byte0_r[status_port_pkg::B0_HARD_ERR] <= 1'b0;
      end
      if (events_i.file_mark_found) byte0_r[status_port_pkg::B0_FILE_MARK] <= 1'b1;
      if (events_i.bad_block_unlocated) byte0_r[status_port_pkg::B0_BAD_BLOCK] <= 1'b1;
      if (events_i.hard_data_error) byte0_r[status_port_pkg::B0_HARD_ERR] <= 1'b1;
      // End of tape latches on the hit and holds while still at logical end
      if (events_i.end_of_tape_hit) begin
        byte0_r[status_port_pkg::B0_END_TAPE] <= 1'b1;
      end else if (!cond_i.end_of_tape) begin
        byte0_r[status_port_pkg::B0_END_TAPE] <= 1'b0;
      end
    end
  end

  // Live conditions plus summary bit
  always_comb begin
    byte0_view = byte0_r;
    byte0_view[status_port_pkg::B0_WPROT] = cond_i.write_protected;
    byte0_view[status_port_pkg::B0_UNSEL] = cond_i.drive_unselected;
    byte0_view[status_port_pkg::B0_NO_CART] = cond_i.cartridge_absent;
    byte0_view[status_port_pkg::ANY_BIT] = |byte0_view[6:0];
  end

  // ----------------------------------------
  // Status byte 1 sticky event bits
  // ----------------------------------------
  // Reset-seen bit: set by internal reset and by the host reset pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte1_r <= status_port_pkg::BYTE1_RESET;
    end else begin
      if (read_done) begin
        byte1_r[status_port_pkg::B1_RESET_SEEN] <= 1'b0;
        byte1_r[status_port_pkg::B1_MARGINAL] <= 1'b0;
        byte1_r[status_port_pkg::B1_NO_DATA] <= 1'b0;
        byte1_r[status_port_pkg::B1_ILLEGAL] <= 1'b0;
      end
      if (hrst_s) byte1_r[status_port_pkg::B1_RESET_SEEN] <= 1'b1;
      if (events_i.marginal_block) byte1_r[status_port_pkg::B1_MARGINAL] <= 1'b1;
      if (events_i.no_data_found) byte1_r[status_port_pkg::B1_NO_DATA] <= 1'b1;
      if (events_i.illegal_command) byte1_r[status_port_pkg::B1_ILLEGAL] <= 1'b1;
    end
  end

  // Tape-start bit is live; reserved bits read zero
  always_comb begin
    byte1_view = byte1_r;
    byte1_view[2:1] = 2'h0;
    byte1_view[status_port_pkg::B1_TAPE_START] = cond_i.at_tape_start;
    byte1_view[status_port_pkg::ANY_BIT] = |byte1_view[6:0];
  end

  // ----------------------------------------
  // Error and stall counters
  // ----------------------------------------
  // Saturate rather than wrap so a flood of errors never reads as few
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_cnt_r <= 16'h0000;
    end else if (events_i.soft_error) begin
      soft_cnt_r <= read_done ? 16'h0001 : sat_inc(soft_cnt_r);
    end else if (read_done) begin
      soft_cnt_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stall_cnt_r <= 16'h0000;
    end else if (events_i.stream_stall) begin
      stall_cnt_r <= read_done ? 16'h0001 : sat_inc(stall_cnt_r);
    end else if (read_done) begin
      stall_cnt_r <= 16'h0000;
    end
  end

  // Byte selection, ascending order, high half first
  always_comb begin
    case (idx_r)
      3'h0: sel_byte = byte0_view;
      3'h1: sel_byte = byte1_view;
      3'h2: sel_byte = soft_cnt_r[15:8];
      3'h3: sel_byte = soft_cnt_r[7:0];
      3'h4: sel_byte = stall_cnt_r[15:8];
      3'h5: sel_byte = stall_cnt_r[7:0];
      default: sel_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Handshake sequencer
  // ----------------------------------------
  // Synchronised host reset forces the quiet state; ready and ack drop on that same edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      tmr_r <= '0;
      test_tmr_r <= 32'h0000_0000;
      idx_r <= 3'h0;
      ready_o <= 1'b0;
      ack_o <= 1'b0;
      exception_o <= 1'b1;
      bus_direction_o <= 1'b0;
      bus_oe_n_o <= 1'b1;
      bus_o <= 8'h00;
      cmd_o <= 8'h00;
      cmd_valid_o <= 1'b0;
    end else if (hrst_s) begin
      state_r <= ST_IDLE;
      ready_o <= 1'b0;
      ack_o <= 1'b0;
      exception_o <= 1'b1;
      bus_direction_o <= 1'b0;
      bus_oe_n_o <= 1'b1;
      idx_r <= 3'h0;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Reset release: run self test when enabled
          if (hrst_d_r && self_test_en_i) begin
            exception_o <= 1'b0;
            test_tmr_r <= 32'h0000_0000;
            state_r <= ST_SELFTEST;
          end else if (hrst_d_r) begin
            ready_o <= 1'b1;
          end else if (req_rise) begin
            ready_o <= 1'b0;
            if (bus_i == status_port_pkg::CMD_READ_STATUS) begin
              tmr_r <= '0;
              state_r <= ST_CMD_WAIT;
            end else begin
              cmd_o <= bus_i;
              cmd_valid_o <= 1'b1;
            end
          end else if (!ready_o && !req_s && !exception_o) begin
            ready_o <= 1'b1;
          end
        end
        ST_SELFTEST: begin
          // Exception comes back within the test window on a pass
          test_tmr_r <= test_tmr_r + 32'h0000_0001;
          if (self_test_pass_i) begin
            exception_o <= 1'b1;
            ready_o <= 1'b1;
            state_r <= ST_IDLE;
          end else if (test_tmr_r == SELF_TEST_CYC - 1) begin
            state_r <= ST_IDLE;
          end
        end
        ST_CMD_WAIT: begin
          // Fixed answer inside the 20 to 500 us window; longer waits never used
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == status_port_pkg::CNT_W'(status_port_pkg::READY_DELAY_CYC - 1)) begin
            exception_o <= 1'b0;
            ready_o <= 1'b1;
            tmr_r <= '0;
            state_r <= ST_CMD_DROP;
          end
        end
        ST_CMD_DROP: begin
          // Ready drop 20 to 100 us after the request falls
          if (!req_s && ready_o) begin
            tmr_r <= tmr_r + 1'b1;
            if (tmr_r == status_port_pkg::CNT_W'(status_port_pkg::DROP_DELAY_CYC - 1)) begin
              ready_o <= 1'b0;
              tmr_r <= '0;
              idx_r <= 3'h0;
              state_r <= ST_BYTE_GAP;
            end
          end
        end
        ST_BYTE_GAP: begin
          // Turn bus toward host and hold off over 20 us before ready
          bus_direction_o <= 1'b1;
          bus_oe_n_o <= 1'b0;
          bus_o <= sel_byte;
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == status_port_pkg::CNT_W'(status_port_pkg::BYTE_GAP_CYC - 1)) begin
            ready_o <= 1'b1;
            tmr_r <= '0;
            state_r <= ST_BYTE_RDY;
          end
        end
        ST_BYTE_RDY: begin
          // Ready drops the cycle after the request is seen
          if (req_rise) begin
            ready_o <= 1'b0;
            state_r <= ST_BYTE_REL;
          end
        end
        ST_BYTE_REL: begin
          if (req_fall) begin
            if (idx_r == status_port_pkg::LAST_BYTE_IDX) begin
              bus_direction_o <= 1'b0;
              bus_oe_n_o <= 1'b1;
              idx_r <= 3'h0;
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 3'h1;
              tmr_r <= '0;
              state_r <= ST_BYTE_GAP;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : tape_status_report_port

`default_nettype wire

// *** inc/status_port_pkg.sv ***
// Constants and types for the tape status report port
// Behaviour
// - Keep six status bytes, return on request
// - Byte0 bit0 file mark, read clears
// - Byte0 bit1 unlocated bad block, read clears
// - Byte0 bit2 hard error, read clears
// - Byte0 bit3 end of tape, sticky
// - Byte0 bits4-6 follow live conditions
// - Byte0 bit7 ORs bits 0-6
// - Byte1 bit0 set by reset, read clears
// - Byte1 bit3 follows tape start, no exception
// - Byte1 bit4 marginal block, no exception
// - Byte1 bit5 no data found, read clears
// - Byte1 bit6 illegal command, read clears
// - Byte1 bit7 ORs others; bits1,2 reserved
// - Bytes 2-3 soft error count, read clears
// - Bytes 4-5 stall count, read clears
// - Reset drops ready/ack, raises exception, releases direction
// - Self test drops exception, re-raises it only on a pass
// - Command handshake: ready 20-500 us, drop 20-100
// - Per byte: turn bus, drive, ready
// - After last byte, turn bus, raise ready
// - Response delay may exceed 500 ms
// - Device alone controls bus direction
`default_nettype none

package status_port_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_STATUS = 8'hC0;

  // ----------------------------------------
  // Status layout
  // ----------------------------------------
  localparam int NUM_STATUS_BYTES = 6;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h5;
  localparam logic [7:0] BYTE0_RESET = 8'h00;
  localparam logic [7:0] BYTE1_RESET = 8'h01;
  localparam int B0_FILE_MARK = 0;
  localparam int B0_BAD_BLOCK = 1;
  localparam int B0_HARD_ERR = 2;
  localparam int B0_END_TAPE = 3;
  localparam int B0_WPROT = 4;
  localparam int B0_UNSEL = 5;
  localparam int B0_NO_CART = 6;
  localparam int B1_RESET_SEEN = 0;
  localparam int B1_TAPE_START = 3;
  localparam int B1_MARGINAL = 4;
  localparam int B1_NO_DATA = 5;
  localparam int B1_ILLEGAL = 6;
  localparam int ANY_BIT = 7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int READY_MIN_US = 20;
  localparam int READY_DELAY_US = 40;
  localparam int BYTE_GAP_US = 25;
  localparam int DROP_DELAY_US = 30;
  localparam int READY_DELAY_CYC = READY_DELAY_US * CLK_MHZ;
  localparam int BYTE_GAP_CYC = BYTE_GAP_US * CLK_MHZ;
  localparam int DROP_DELAY_CYC = DROP_DELAY_US * CLK_MHZ;
  localparam int SELF_TEST_S = 5;
  localparam int SELF_TEST_CYC_DEFAULT = 1000;
  localparam int CNT_W = 24;

  // ----------------------------------------
  // Event and condition carriers
  // ----------------------------------------
  typedef struct packed {
    logic file_mark_found;
    logic bad_block_unlocated;
    logic hard_data_error;
    logic end_of_tape_hit;
    logic marginal_block;
    logic no_data_found;
    logic illegal_command;
    logic soft_error;
    logic stream_stall;
  } event_type;

  typedef struct packed {
    logic end_of_tape;
    logic write_protected;
    logic drive_unselected;
    logic cartridge_absent;
    logic at_tape_start;
  } cond_type;

endpackage : status_port_pkg

`default_nettype wire

// *** design/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic init_i,
  // Pin
  input wire logic pin_i,
  output logic level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------
  // Chain; first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
    end else if (init_i) begin
      level_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule : pin_sync

`default_nettype wire

// *** verif/status_port_asserts.sv ***
// Concurrent checks on the status port pins
`default_nettype none

module status_port_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Host port pins
  input wire logic host_reset_i,
  input wire logic request_i,
  input wire logic [7:0] bus_o,
  input wire logic bus_oe_n_o,
  input wire logic ready_o,
  input wire logic ack_o,
  input wire logic exception_o,
  input wire logic bus_direction_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_cnt_r;
  logic [15:0] rql_cnt_r;
  logic [2:0] idx_r;
  logic rdy_q_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Run lengths of ready low and request low; saturate so long idles never wrap
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_r <= 16'h0000;
      rql_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= ready_o ? 16'h0000 : low_cnt_r + {15'h0, ~&low_cnt_r};
      rql_cnt_r <= request_i ? 16'h0000 : rql_cnt_r + {15'h0, ~&rql_cnt_r};
    end
  end

  // Byte index; only a drop seen with the bus already turned moves it on
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_r <= 3'h0;
      rdy_q_r <= 1'b0;
    end else begin
      rdy_q_r <= ready_o & bus_direction_o;
      if (!bus_direction_o) idx_r <= 3'h0;
      else if (rdy_q_r && !ready_o) idx_r <= idx_r + 3'h1;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_low: assert property (!ack_o)
    else $error("ack raised");
  a_reset_state: assert property (host_reset_i [*8] |->
    !ready_o && !ack_o && exception_o && !bus_direction_o) else $error("reset pins wrong");
  a_status_ready: assert property ($rose(ready_o) && request_i && !bus_direction_o |->
    low_cnt_r >= 16'h03E8 && low_cnt_r <= 16'h61A8 && !exception_o)
    else $error("status ready timing");
  a_drop_delay: assert property ($fell(ready_o) && !request_i && !bus_direction_o
    && !host_reset_i |-> rql_cnt_r >= 16'h03E8 && rql_cnt_r <= 16'h1388)
    else $error("ready drop timing");
  a_byte_quick: assert property ($rose(request_i) && ready_o && bus_direction_o |->
    ##[1:50] !ready_o) else $error("byte ready slow");
  a_byte_gap: assert property ($rose(ready_o) && bus_direction_o |->
    low_cnt_r >= 16'h03E8) else $error("byte gap short");
  a_byte0_or: assert property (ready_o && bus_direction_o && idx_r == 3'h0 |->
    bus_o[7] == |bus_o[6:0]) else $error("byte0 summary");
  a_byte1_or: assert property (ready_o && bus_direction_o && idx_r == 3'h1 |->
    bus_o[2:1] == 2'h0 && bus_o[7] == |{bus_o[6:3], bus_o[0]}) else $error("byte1 summary");
  a_bus_owner: assert property (!bus_direction_o && !$past(bus_direction_o) |->
    bus_oe_n_o) else $error("bus driven toward device");
  a_turn_first: assert property ($fell(bus_direction_o) |-> !ready_o)
    else $error("ready before turn");

  c_host_reset: cover property (host_reset_i [*8]);
  c_byte_five: cover property (ready_o && bus_direction_o && idx_r == 3'h5);
  c_status_done: cover property ($fell(bus_direction_o) ##[1:50] ready_o);
endmodule : status_port_asserts

bind tape_status_report_port status_port_asserts chk_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .host_reset_i(host_reset_i), .request_i(request_i),
  .bus_o(bus_o), .bus_oe_n_o(bus_oe_n_o), .ready_o(ready_o), .ack_o(ack_o),
  .exception_o(exception_o), .bus_direction_o(bus_direction_o));

`default_nettype wire

// *** verif/host_port_model.sv ***
// Host adapter model on the parallel status port
`default_nettype none

module host_port_model (
  // Clock
  input wire logic clk_i,
  // Device pins
  input wire logic ready_i,
  input wire logic exc_i,
  input wire logic dir_i,
  input wire logic [7:0] dev_bus_i,
  // Host pins
  output var logic host_reset_o,
  output var logic request_o,
  output var logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    host_reset_o = 1'b0;
    request_o = 1'b0;
    bus_o = 8'h00;
  end

  // Released drivers: the wire churns so a stale command never passes for data
  always @(negedge clk_i) begin
    if (dir_i) bus_o <= ~bus_o;
  end

  // Host reset held past its minimum width
  task pulse_reset();
    @(negedge clk_i) host_reset_o = 1'b1;
    repeat (1300) @(negedge clk_i);
    host_reset_o = 1'b0;
  endtask : pulse_reset

  // Command handshake, then six bytes with request held over 20 us each
  task read_status(output logic [47:0] data);
    data = 48'h0;
    // After power-on reset a pending exception leaves ready low, and status is then the only answer
    @(posedge clk_i iff (ready_i || exc_i));
    @(negedge clk_i) bus_o = status_port_pkg::CMD_READ_STATUS;
    @(negedge clk_i) request_o = 1'b1;
    @(posedge clk_i iff !ready_i);
    @(posedge clk_i iff ready_i);
    @(negedge clk_i) request_o = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i iff (ready_i && dir_i));
      data = {data[39:0], dev_bus_i};
      @(negedge clk_i) request_o = 1'b1;
      @(posedge clk_i iff !ready_i);
      repeat (1050) @(negedge clk_i);
      request_o = 1'b0;
    end
    @(posedge clk_i iff (ready_i && !dir_i));
  endtask : read_status

  // Any other command: request until ready drops, then wait for ready again
  task send_cmd(input logic [7:0] code);
    @(posedge clk_i iff ready_i);
    @(negedge clk_i) bus_o = code;
    @(negedge clk_i) request_o = 1'b1;
    @(posedge clk_i iff !ready_i);
    @(negedge clk_i) request_o = 1'b0;
    @(posedge clk_i iff ready_i);
  endtask : send_cmd
endmodule : host_port_model

`default_nettype wire

// *** verif/tape_status_report_port_test.sv ***
// Self-checking bench for the tape status report port
`default_nettype none

module tape_status_report_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic host_reset, request, bus_oe_n, ready, ack, exception, dir;
  logic [7:0] hbus;
  logic [7:0] dbus;
  status_port_pkg::event_type ev = '0;
  status_port_pkg::event_type acc = '0;
  status_port_pkg::cond_type cond = '0;
  logic st_en = 1'b0;
  logic st_pass = 1'b0;
  logic eot = 1'b0;
  logic por = 1'b1;
  logic [15:0] soft_n = 16'h0000;
  logic [15:0] stall_n = 16'h0000;
  logic [47:0] got;
  logic [7:0] cmd_b;
  logic cmd_v;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_seen = 8'h00;
  int cmd_pulses = 0;
  int seed = 32'hCE5DACED;
  int errors = 0;
  int total_checks = 0;

  always #10 clk_i = ~clk_i;

  tape_status_report_port #(.SELF_TEST_CYC(100)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .host_reset_i(host_reset), .request_i(request),
    .bus_i(hbus), .bus_o(dbus), .bus_oe_n_o(bus_oe_n), .ready_o(ready), .ack_o(ack),
    .exception_o(exception), .bus_direction_o(dir), .events_i(ev), .cond_i(cond),
    .self_test_en_i(st_en), .self_test_pass_i(st_pass), .cmd_o(cmd_b), .cmd_valid_o(cmd_v));

  host_port_model host_u (
    .clk_i(clk_i), .ready_i(ready), .exc_i(exception), .dir_i(dir), .dev_bus_i(dbus),
    .host_reset_o(host_reset), .request_o(request), .bus_o(hbus));

  // Command pulse stands one cycle, so the falling edge sees it exactly once
  always @(negedge clk_i) begin
    if (cmd_v) begin
      cmd_seen <= cmd_b;
      cmd_pulses <= cmd_pulses + 1;
    end
  end

  // ----------------------------------------
  // Expectation and reporting
  // ----------------------------------------
  // Six bytes as the host should see them, byte 0 first
  function automatic logic [47:0] exp_status();
    logic [6:0] b0;
    logic [6:0] b1;
    b0 = {cond.cartridge_absent, cond.drive_unselected, cond.write_protected, eot,
      acc.hard_data_error, acc.bad_block_unlocated, acc.file_mark_found};
    b1 = {acc.illegal_command, acc.no_data_found, acc.marginal_block, cond.at_tape_start,
      2'h0, por};
    return {|b0, b0, |b1, b1, soft_n, stall_n};
  endfunction : exp_status

  task check_val(input string what, input logic [47:0] exp, input logic [47:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  task end_sim();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // One status read; the read-clear bits and counters are then expected gone
  task status_round(input string what);
    host_u.read_status(got);
    check_val(what, exp_status(), got);
    acc = '0;
    soft_n = 16'h0000;
    stall_n = 16'h0000;
    por = 1'b0;
  endtask : status_round

  // Random events, spaced so back-to-back pulses are not merged into one
  task burst(input int n);
    repeat (n) begin
      @(negedge clk_i);
      ev = 9'($random(seed));
      acc = acc | ev;
      soft_n += {15'h0, ev.soft_error};
      stall_n += {15'h0, ev.stream_stall};
      eot |= ev.end_of_tape_hit & cond.end_of_tape;
      @(negedge clk_i) ev = '0;
    end
  endtask : burst

  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge clk_i);
    cond = 5'($random(seed));
    cond.end_of_tape = 1'b1;
    burst(30);
    status_round("status events");
    cmd_code = 8'($random(seed));
    if (cmd_code == status_port_pkg::CMD_READ_STATUS) cmd_code = 8'h01;
    host_u.send_cmd(cmd_code);
    check_val("command code", {40'h0, cmd_code}, {40'h0, cmd_seen});
    check_val("command pulses", 48'h1, 48'(cmd_pulses));
    @(negedge clk_i) ev.marginal_block = 1'b1;
    @(negedge clk_i) ev = '0;
    acc.marginal_block = 1'b1;
    cond.at_tape_start = ~cond.at_tape_start;
    repeat (20) @(negedge clk_i);
    check_val("exception quiet", 48'h0, {47'h0, exception});
    status_round("status reread");
    @(negedge clk_i);
    cond.end_of_tape = 1'b0;
    eot = 1'b0;
    st_en = 1'b1;
    fork
      host_u.pulse_reset();
      begin
        repeat (100) @(negedge clk_i);
        check_val("reset pins", 48'h2, {44'h0, ready, ack, exception, dir});
      end
    join
    repeat (10) @(negedge clk_i);
    check_val("self test drop", 48'h0, {47'h0, exception});
    @(negedge clk_i) st_pass = 1'b1;
    @(negedge clk_i) st_pass = 1'b0;
    repeat (5) @(negedge clk_i);
    check_val("self test pass", 48'h1, {47'h0, exception});
    por = 1'b1;
    status_round("status host reset");
    @(negedge clk_i) st_en = 1'b0;
    host_u.pulse_reset();
    repeat (10) @(negedge clk_i);
    check_val("plain reset", 48'h3, {46'h0, ready, exception});
    end_sim();
  end

  // Three status rounds of some 18k cycles each plus two host resets
  initial begin
    repeat (80000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule : tape_status_report_port_test

`default_nettype wire
